// ==== shared/ccbl_pkg.sv ====
// Constants and types for the charger configuration and indicator blink block
//
// Functional notes
// - Reset-pulse bit picks 1000 ms or 69 ms
// - Restart bit holds charger, restarts on clear
// - Timer enable bit gates both charge timers
// - Current field selects 100/75/50/32 percent
// - USB limit 100/500 mA, ignored without permission
// - USB permission bit allows USB charging
// - Charge enable; wall adapter preferred over USB
// - First indicator modes: charger, blink, off, on
// - Charger mode: conduct when any source valid
// - First on-time: 10 ms per step
// - First period: 100 ms per step
// - Second on-time: 10 ms per step
// - Second period: 100 ms per step
// - Second indicator modes: off, blink, off, on
package ccbl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES_DEF = CLK_MHZ * TICK_US;
  localparam int unsigned POR_LONG_MS = 1000;
  localparam int unsigned POR_SHORT_MS = 69;
  localparam int unsigned ON_STEP_MS = 10;
  localparam int unsigned PER_STEP_MS = 100;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [7:0] REG_CFG = 8'h07;
  localparam logic [7:0] REG_ON1 = 8'h08;
  localparam logic [7:0] REG_PER1 = 8'h09;
  localparam logic [7:0] REG_ON2 = 8'h0a;
  localparam logic [7:0] REG_PER2 = 8'h0b;
  localparam logic [7:0] RST_CFG = 8'h1b;
  localparam logic [7:0] RST_LED = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CFG_POR = 7;
  localparam int unsigned CFG_CHG_RST = 6;
  localparam int unsigned CFG_TMR_EN = 5;
  localparam int unsigned CFG_CUR_HI = 4;
  localparam int unsigned CFG_CUR_LO = 3;
  localparam int unsigned CFG_USB_500 = 2;
  localparam int unsigned CFG_USB_OK = 1;
  localparam int unsigned CFG_CHG_EN = 0;
  localparam int unsigned MODE_BIT = 7;
  localparam int unsigned FIELD_MSB = 6;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_CHARGER = 2'h0;
  localparam logic [1:0] MODE_BLINK = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  localparam logic [1:0] MODE_ON = 2'h3;
  localparam logic [1:0] CUR_FULL = 2'h3;
  localparam logic [1:0] CUR_75 = 2'h2;
  localparam logic [1:0] CUR_50 = 2'h1;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_75 = 7'h4b;
  localparam logic [6:0] PCT_50 = 7'h32;
  localparam logic [6:0] PCT_32 = 7'h20;

  // Serial slave states, Gray along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_PTR  = 4'h2,
    ST_PACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WACK = 4'h5,
    ST_RDAT = 4'h4,
    ST_RACK = 4'hc
  } ccbl_i2c_t;

endpackage

// ==== logic/ccbl_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ccbl_sync
  import ccbl_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } ccbl_sync_t;

  ccbl_sync_t st_r;
  ccbl_sync_t st_nxt;

  always_comb begin
    st_nxt.ff1 = din;
    st_nxt.ff2 = st_r.ff1;
  end

  // Reset to each pin's idle level so no false edge or event follows reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.ff2;

endmodule

// ==== logic/ccbl_blink.sv ====
// Blink generator: conducts for the on-time at the start of each period
`timescale 1ns/1ps
module ccbl_blink
  import ccbl_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic [6:0] on_field,
  input wire logic [6:0] per_field,
  // Result
  output logic conduct
);

  typedef struct packed {
    logic [13:0] cnt;
    logic conduct;
  } ccbl_blink_t;

  ccbl_blink_t st_r;
  ccbl_blink_t st_nxt;
  logic [13:0] on_lim;
  logic [13:0] per_lim;

  always_comb begin
    st_nxt = st_r;
    on_lim = 14'((int'(on_field) + 1) * ON_STEP_MS);
    per_lim = 14'((int'(per_field) + 1) * PER_STEP_MS);
    if (!enable) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      // Wrap also catches a period shortened below the running count
      if (st_r.cnt + 14'h1 >= per_lim) begin
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 14'h1;
      end
    end
    st_nxt.conduct = enable && (st_r.cnt < on_lim);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conduct = st_r.conduct;

endmodule

// ==== logic/ccbl_top.sv ====
// Charger configuration and indicator registers behind a serial slave
`timescale 1ns/1ps
module ccbl_top
  import ccbl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial interface, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Source detection pins
  input wire logic usb_valid,
  input wire logic ac_valid,
  // Power-on reset pulse
  input wire logic por_request,
  output logic reset_pulse_n,
  // Charger control
  output logic charger_hold_reset,
  output logic charger_restart,
  output logic charge_timers_enable,
  output logic [6:0] charge_current_pct,
  output logic charge_from_ac,
  output logic charge_from_usb,
  output logic usb_limit_500ma,
  // First indicator, open drain
  input wire logic first_indicator_output_in,
  output logic first_indicator_output_out,
  output logic first_indicator_output_oe,
  // Second indicator, open drain
  input wire logic second_indicator_output_in,
  output logic second_indicator_output_out,
  output logic second_indicator_output_oe
);

  localparam int unsigned TW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] on1;
    logic [7:0] per1;
    logic [7:0] on2;
    logic [7:0] per2;
    ccbl_i2c_t st;
    logic [2:0] cnt;
    logic full;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic scl_d;
    logic sda_d;
    logic sda_oe;
    logic od_lvl;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [9:0] por_cnt;
    logic por_n;
    logic chg_hold;
    logic chg_restart;
    logic tmr_en;
    logic [6:0] pct;
    logic from_ac;
    logic from_usb;
    logic usb_500;
    logic ind1;
    logic ind2;
  } ccbl_state_t;

  ccbl_state_t st_r;
  ccbl_state_t st_nxt;
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic usb_s;
  logic ac_s;
  logic [1:0][7:0] ch_on;
  logic [1:0][7:0] ch_per;
  logic [1:0][1:0] ch_mode;
  logic [1:0] blink_c;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [9:0] por_lim;

  // ----------------------------------------
  // Pin synchronisers and blink generators
  // ----------------------------------------
  // Bus pins reset idle high, source pins reset absent: no charging path opens at reset
  ccbl_sync #(.W(4), .RST_VAL(4'hc)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({scl_in, sda_in, usb_valid, ac_valid}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign usb_s = pins_s[1];
  assign ac_s = pins_s[0];
  assign ch_on = {st_r.on2, st_r.on1};
  assign ch_per = {st_r.per2, st_r.per1};

  for (genvar g = 0; g < 2; g++) begin : g_blink
    assign ch_mode[g] = {ch_on[g][MODE_BIT], ch_per[g][MODE_BIT]};
    ccbl_blink u_blink (
      .mclk(mclk),
      .reset(reset),
      .tick(st_r.tick),
      .enable(ch_mode[g] == MODE_BLINK),
      .on_field(ch_on[g][FIELD_MSB:0]),
      .per_field(ch_per[g][FIELD_MSB:0]),
      .conduct(blink_c[g])
    );
  end

  // ----------------------------------------
  // Bus events and read mux
  // ----------------------------------------
  assign scl_rise = scl_s && !st_r.scl_d;
  assign scl_fall = !scl_s && st_r.scl_d;
  assign start_c = scl_s && st_r.scl_d && st_r.sda_d && !sda_s;
  assign stop_c = scl_s && st_r.scl_d && !st_r.sda_d && sda_s;

  always_comb begin
    case (st_r.ptr)
      REG_CFG: rd_byte = st_r.cfg;
      REG_ON1: rd_byte = st_r.on1;
      REG_PER1: rd_byte = st_r.per1;
      REG_ON2: rd_byte = st_r.on2;
      REG_PER2: rd_byte = st_r.per2;
      default: rd_byte = RD_UNMAPPED;
    endcase
  end

  assign por_lim = st_r.cfg[CFG_POR] ? 10'(POR_SHORT_MS) : 10'(POR_LONG_MS);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end

    // Serial slave; data is sampled on SCL rise and driven on SCL fall
    if (start_c) begin
      st_nxt.st = ST_ADDR;
      st_nxt.cnt = '0;
      st_nxt.full = 1'b0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      st_nxt.st = ST_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      unique case (st_r.st)
        ST_IDLE: begin
          st_nxt.sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDAT: begin
          if (scl_rise) begin
            st_nxt.sh = {st_r.sh[6:0], sda_s};
            st_nxt.cnt = st_r.cnt + 3'h1;
            st_nxt.full = (st_r.cnt == 3'h7);
          end else if (scl_fall && st_r.full) begin
            st_nxt.full = 1'b0;
            st_nxt.sda_oe = 1'b1;
            if (st_r.st == ST_ADDR) begin
              // Foreign address: stay silent until the next start
              if (st_r.sh[7:1] == DEV_ADDR) begin
                st_nxt.rw = st_r.sh[0];
                st_nxt.st = ST_AACK;
              end else begin
                st_nxt.sda_oe = 1'b0;
                st_nxt.st = ST_IDLE;
              end
            end else if (st_r.st == ST_PTR) begin
              st_nxt.ptr = st_r.sh;
              st_nxt.st = ST_PACK;
            end else begin
              // restart bit is only cleared by a host write
              case (st_r.ptr)
                REG_CFG: st_nxt.cfg = st_r.sh;
                REG_ON1: st_nxt.on1 = st_r.sh;
                REG_PER1: st_nxt.per1 = st_r.sh;
                REG_ON2: st_nxt.on2 = st_r.sh;
                REG_PER2: st_nxt.per2 = st_r.sh;
                default: st_nxt.cfg = st_r.cfg;
              endcase
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.st = ST_WACK;
            end
          end
        end
        ST_AACK, ST_RACK: begin
          if (scl_rise && st_r.st == ST_RACK) begin
            st_nxt.nack = sda_s;
          end else if (scl_fall) begin
            st_nxt.cnt = '0;
            st_nxt.sda_oe = 1'b0;
            if (st_r.st == ST_AACK && !st_r.rw) begin
              st_nxt.st = ST_PTR;
            end else if (st_r.st == ST_RACK && st_r.nack) begin
              st_nxt.st = ST_IDLE;
            end else begin
              st_nxt.sh = rd_byte;
              st_nxt.sda_oe = !rd_byte[7];
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.st = ST_RDAT;
            end
          end
        end
        ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.cnt = '0;
            st_nxt.st = ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            st_nxt.cnt = st_r.cnt + 3'h1;
            st_nxt.full = (st_r.cnt == 3'h7);
          end else if (scl_fall) begin
            if (st_r.full) begin
              st_nxt.full = 1'b0;
              st_nxt.sda_oe = 1'b0;
              st_nxt.nack = 1'b0;
              st_nxt.st = ST_RACK;
            end else begin
              st_nxt.sh = {st_r.sh[6:0], 1'b0};
              st_nxt.sda_oe = !st_r.sh[6];
            end
          end
        end
        default: begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.st = ST_IDLE;
        end
      endcase
    end

    if (por_request) begin
      st_nxt.por_n = 1'b0;
      st_nxt.por_cnt = '0;
    end else if (!st_r.por_n && st_r.tick) begin
      if (st_r.por_cnt + 10'h1 >= por_lim) begin
        st_nxt.por_n = 1'b1;
      end else begin
        st_nxt.por_cnt = st_r.por_cnt + 10'h1;
      end
    end

    st_nxt.chg_hold = st_r.cfg[CFG_CHG_RST];
    st_nxt.chg_restart = st_r.chg_hold && !st_r.cfg[CFG_CHG_RST];
    // timers gated, and cleared while held
    st_nxt.tmr_en = st_r.cfg[CFG_TMR_EN] && !st_r.cfg[CFG_CHG_RST];
    case ({st_r.cfg[CFG_CUR_HI], st_r.cfg[CFG_CUR_LO]})
      CUR_FULL: st_nxt.pct = PCT_FULL;
      CUR_75: st_nxt.pct = PCT_75;
      CUR_50: st_nxt.pct = PCT_50;
      default: st_nxt.pct = PCT_32;
    endcase
    st_nxt.from_ac = st_r.cfg[CFG_CHG_EN] && !st_r.cfg[CFG_CHG_RST] && ac_s;
    st_nxt.from_usb = st_r.cfg[CFG_CHG_EN] && !st_r.cfg[CFG_CHG_RST] &&
                      st_r.cfg[CFG_USB_OK] && usb_s && !ac_s;
    st_nxt.usb_500 = st_r.cfg[CFG_USB_OK] && st_r.cfg[CFG_USB_500];

    unique case (ch_mode[0])
      // conduct when a source is valid
      MODE_CHARGER: st_nxt.ind1 = usb_s || ac_s;
      MODE_BLINK: st_nxt.ind1 = blink_c[0];
      MODE_OFF: st_nxt.ind1 = 1'b0;
      MODE_ON: st_nxt.ind1 = 1'b1;
    endcase
    unique case (ch_mode[1])
      MODE_BLINK: st_nxt.ind2 = blink_c[1];
      MODE_ON: st_nxt.ind2 = 1'b1;
      MODE_CHARGER, MODE_OFF: st_nxt.ind2 = 1'b0;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
      st_r.cfg <= RST_CFG;
      st_r.on1 <= RST_LED;
      st_r.per1 <= RST_LED;
      st_r.on2 <= RST_LED;
      st_r.per2 <= RST_LED;
      st_r.st <= ST_IDLE;
      st_r.scl_d <= 1'b1;
      st_r.sda_d <= 1'b1;
      st_r.pct <= PCT_FULL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out = st_r.od_lvl;
  assign sda_oe = st_r.sda_oe;
  assign reset_pulse_n = st_r.por_n;
  assign charger_hold_reset = st_r.chg_hold;
  assign charger_restart = st_r.chg_restart;
  assign charge_timers_enable = st_r.tmr_en;
  assign charge_current_pct = st_r.pct;
  assign charge_from_ac = st_r.from_ac;
  assign charge_from_usb = st_r.from_usb;
  assign usb_limit_500ma = st_r.usb_500;
  assign first_indicator_output_out = st_r.od_lvl;
  assign first_indicator_output_oe = st_r.ind1;
  assign second_indicator_output_out = st_r.od_lvl;
  assign second_indicator_output_oe = st_r.ind2;

endmodule

// ==== tb/ccbl_properties.sv ====
// Checker for the charger configuration and indicator block
`timescale 1ns/1ps
module ccbl_properties
  import ccbl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins
  input wire logic sda_out,
  input wire logic first_indicator_output_out,
  input wire logic second_indicator_output_out,
  input wire logic first_indicator_output_oe,
  input wire logic por_request,
  input wire logic reset_pulse_n,
  // Charger control
  input wire logic charger_hold_reset,
  input wire logic charger_restart,
  input wire logic charge_timers_enable,
  input wire logic [6:0] charge_current_pct,
  input wire logic charge_from_ac,
  input wire logic charge_from_usb
);
  localparam int MIN_LOW = (POR_SHORT_MS - 2) * TICK_CYCLES;
  localparam int MAX_LOW = (POR_LONG_MS + 2) * TICK_CYCLES;
  logic [15:0] low_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Low time of the reset pulse; a new request starts the count again
  always_ff @(posedge mclk) begin
    if (reset || reset_pulse_n || por_request) begin
      low_cnt_r <= 16'h0000;
    end else if (low_cnt_r != 16'hffff) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end
  od_levels_a: assert property (
    !sda_out && !first_indicator_output_out && !second_indicator_output_out)
    else $error("open-drain pin driven high");
  cur_code_a: assert property (
    charge_current_pct inside {7'h64, 7'h4b, 7'h32, 7'h20}) else $error("bad current level");
  hold_block_a: assert property (
    charger_hold_reset |-> !charge_timers_enable && !charge_from_ac && !charge_from_usb)
    else $error("charger active while held");
  restart_edge_a: assert property (
    charger_restart |-> !charger_hold_reset &&
    ($past(charger_hold_reset) || $past(charger_hold_reset, 2))) else $error("stray restart");
  restart_once_a: assert property (
    charger_restart |=> !charger_restart) else $error("restart longer than one cycle");
  ac_first_a: assert property (
    charge_from_usb |-> !charge_from_ac) else $error("both sources selected");
  por_min_a: assert property (
    $rose(reset_pulse_n) |-> low_cnt_r >= MIN_LOW) else $error("reset pulse too short");
  por_max_a: assert property (
    low_cnt_r <= MAX_LOW) else $error("reset pulse too long");
  cover property (charger_restart);
  cover property ($rose(first_indicator_output_oe));
  cover property ($rose(reset_pulse_n));
  cover property (charge_from_usb);
endmodule

bind ccbl_top ccbl_properties #(.TICK_CYCLES(TICK_CYCLES)) u_ccbl_properties (
  .mclk(mclk), .reset(reset), .sda_out(sda_out),
  .first_indicator_output_out(first_indicator_output_out),
  .second_indicator_output_out(second_indicator_output_out),
  .first_indicator_output_oe(first_indicator_output_oe), .por_request(por_request),
  .reset_pulse_n(reset_pulse_n), .charger_hold_reset(charger_hold_reset),
  .charger_restart(charger_restart), .charge_timers_enable(charge_timers_enable),
  .charge_current_pct(charge_current_pct), .charge_from_ac(charge_from_ac),
  .charge_from_usb(charge_from_usb));

// ==== tb/ccbl_host.sv ====
// Serial host model that writes and reads the block's registers
`timescale 1ns/1ps
module ccbl_host (
  // Clock
  input wire logic mclk,
  // Serial pins, open drain
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One phase of four cycles; data bits move SDA only with SCL low, past the slave's hold window
  task automatic ph(input logic c, input logic l);
    scl = c;
    sda_low = l;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic s);
    ph(1'b0, ~b);
    ph(1'b1, ~b);
    s = sda;
    ph(1'b1, ~b);
    ph(1'b0, ~b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(mack, s);
    ack = ~s;
  endtask
  task automatic start();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    xfer({a, 1'b0}, 1'b1, q, k1);
    xfer(p, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // Last byte of a read is refused so the slave lets go before the stop
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic k1, k2, k3, k4;
    start();
    xfer({a, 1'b0}, 1'b1, q, k1);
    xfer(p, 1'b1, q, k2);
    start();
    xfer({a, 1'b1}, 1'b1, q, k3);
    xfer(8'hff, 1'b1, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule

// ==== tb/ccbl_top_bench.sv ====
// Self-checking bench for the charger configuration and indicator block
`timescale 1ns/1ps
module ccbl_top_bench;
  import ccbl_pkg::*;
  // Short millisecond tick keeps the long pulses affordable
  localparam int unsigned TK = 10;
  localparam logic [6:0] DA = 7'h48;
  logic mclk, reset, usb_valid, ac_valid, por_request, scl, host_low, ok, sel;
  logic sda_out, sda_oe, reset_pulse_n, charger_hold_reset, charger_restart;
  logic charge_timers_enable, charge_from_ac, charge_from_usb, usb_limit_500ma;
  logic ind1_out, ind1_oe, ind2_out, ind2_oe;
  logic [6:0] charge_current_pct;
  logic [7:0] r, v;
  logic [31:0] rnd;
  int bad_count, samples_checked, cyc, n, restarts;
  wire logic sda = ~(host_low | sda_oe);
  ccbl_top #(.TICK_CYCLES(TK), .DEV_ADDR(DA)) u_ccbl_top (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .usb_valid(usb_valid), .ac_valid(ac_valid), .por_request(por_request),
    .reset_pulse_n(reset_pulse_n), .charger_hold_reset(charger_hold_reset),
    .charger_restart(charger_restart), .charge_timers_enable(charge_timers_enable),
    .charge_current_pct(charge_current_pct), .charge_from_ac(charge_from_ac),
    .charge_from_usb(charge_from_usb), .usb_limit_500ma(usb_limit_500ma),
    .first_indicator_output_in(~ind1_oe), .first_indicator_output_out(ind1_out),
    .first_indicator_output_oe(ind1_oe), .second_indicator_output_in(~ind2_oe),
    .second_indicator_output_out(ind2_out), .second_indicator_output_oe(ind2_oe));
  ccbl_host u_ccbl_host (.mclk(mclk), .scl(scl), .sda_low(host_low), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_ccbl_host.write_reg(DA, p, d, ok);
    check(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    u_ccbl_host.read_reg(DA, p, d, ok);
    check(ok, 1'b1);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] exp_pct(input logic [1:0] c);
    return (c == 2'h3) ? 7'h64 : (c == 2'h2) ? 7'h4b : (c == 2'h1) ? 7'h32 : 7'h20;
  endfunction
  task automatic span(input logic lvl, output int k);
    k = 0;
    while ((sel ? ind2_oe : ind1_oe) === lvl && k < 9000) begin
      step(1);
      k++;
    end
  endtask
  // one full blink period after a partial one
  task automatic blink(input logic s, input int hi, input int lo);
    sel = s;
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, n);
    check(16'(n), 16'(hi));
    span(1'b0, n);
    check(16'(n), 16'(lo));
  endtask
  always @(posedge mclk) begin
    cyc++;
    // A restart pulse held too long counts more than once
    if (charger_restart === 1'b1) begin
      restarts++;
    end
    if (cyc == 80000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    usb_valid = 1'b0;
    ac_valid = 1'b0;
    por_request = 1'b0;
    sel = 1'b0;
    rnd = 32'h9c93_0cfc;
    step(20);
    reset = 1'b0;
    n = 0;
    while (reset_pulse_n !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    check(n >= 998 * TK && n <= 1002 * TK, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rd(8'h07 + i[7:0], r);
      check(r, (i == 0) ? RST_CFG : (i == 5) ? RD_UNMAPPED : RST_LED);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      v[6] = 1'b0;
      v[4:3] = i[1:0];
      usb_valid = rnd[8];
      ac_valid = rnd[9];
      // Both sources valid with USB allowed: the adapter must win
      if (i == 7) begin
        usb_valid = 1'b1;
        ac_valid = 1'b1;
        v[1:0] = 2'h3;
      end
      wr(REG_CFG, v);
      rd(REG_CFG, r);
      check(r, v);
      check(charge_current_pct, exp_pct(v[4:3]));
      check(charge_timers_enable, v[5]);
      check(usb_limit_500ma, v[1] & v[2]);
      check(charge_from_ac, v[0] & ac_valid);
      check(charge_from_usb, v[0] & v[1] & usb_valid & ~ac_valid);
    end
    // A foreign address gets no acknowledge and leaves the registers alone
    u_ccbl_host.write_reg(DA ^ 7'h01, REG_CFG, 8'h00, ok);
    check(ok, 1'b0);
    rd(REG_CFG, r);
    check(r, v);
    $display("test configuration done");
    ac_valid = 1'b1;
    wr(REG_CFG, 8'h79);
    check(charger_hold_reset, 1'b1);
    check(16'(restarts), 16'h0000);
    check(charge_timers_enable | charge_from_ac, 1'b0);
    wr(REG_CFG, 8'h39);
    check(charger_hold_reset, 1'b0);
    check(16'(restarts), 16'h0001);
    check(charge_timers_enable & charge_from_ac, 1'b1);
    wr(REG_CFG, 8'h9b);
    por_request = 1'b1;
    step(1);
    por_request = 1'b0;
    n = 0;
    while (reset_pulse_n !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    n = 0;
    while (reset_pulse_n !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    check(n >= 68 * TK && n <= 70 * TK, 1'b1);
    $display("test restart and short pulse done");
    usb_valid = 1'b1;
    ac_valid = 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(REG_ON1, {m[1], 7'h02});
      wr(REG_PER1, {m[0], 7'h00});
      wr(REG_ON2, {m[1], 7'h04});
      wr(REG_PER2, {m[0], 7'h01});
      step(4);
      if (m == 1) begin
        blink(1'b0, 30 * TK, 70 * TK);
        blink(1'b1, 50 * TK, 150 * TK);
      end else begin
        check(ind1_oe, (m == 0) | (m == 3));
        check(ind2_oe, m == 3);
      end
    end
    wr(REG_ON1, 8'h00);
    wr(REG_PER1, 8'h00);
    usb_valid = 1'b0;
    step(5);
    check(ind1_oe, 1'b0);
    $display("test indicators done");
    give_verdict();
  end
endmodule
